// ---- logic/sbsc_cfg.svh ----
`ifndef SBSC_CFG_SVH
`define SBSC_CFG_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define SBSC_ADDR_W     19
`define SBSC_LANES      4
`define SBSC_LANE_W     9
`define SBSC_BURST_W    2

// ----------------------------------------
// Burst counter values
// ----------------------------------------
`define SBSC_CNT_ZERO   2'h0
`define SBSC_CNT_STEP   2'h1

// ----------------------------------------
// Mode pin synchroniser: {parity, order, flowthru, sleep}
// ----------------------------------------
`define SBSC_MODE_W     4
`define SBSC_MODE_RST   4'he
`define SBSC_MODE_SLEEP 0
`define SBSC_MODE_FLOW  1
`define SBSC_MODE_ORDER 2
`define SBSC_MODE_PAR   3

`endif

// ---- logic/sbsc_pkg.sv ----
package sbsc_pkg;

	// ----------------------------------------
	// Cycle kinds
	// ----------------------------------------
	typedef enum logic [2:0] {
		SBSC_DESEL = 3'h1,
		SBSC_READ  = 3'h2,
		SBSC_WRITE = 3'h4
	} sbsc_kind_t;

endpackage

// ---- logic/sbsc_top.sv ----
`include "sbsc_cfg.svh"

module sbsc_top #(
	parameter int ADDR_W = `SBSC_ADDR_W,
	parameter int LANES  = `SBSC_LANES,
	parameter int LANE_W = `SBSC_LANE_W
) (
	input  wire logic                      CLK,
	input  wire logic                      RSTN,
	input  wire logic [ADDR_W-1:0]         ADDR,
	input  wire logic                      CHIP_SELECT_N,
	input  wire logic                      PROC_ADDR_STROBE_N,
	input  wire logic                      CTRL_ADDR_STROBE_N,
	input  wire logic                      BURST_ADVANCE_N,
	input  wire logic                      BYTE_WRITE_EN_N,
	input  wire logic                      ALL_BYTES_WRITE_N,
	input  wire logic [LANES-1:0]          BYTE_LANE_EN_N,
	input  wire logic                      OUTPUT_ENABLE_N,
	input  wire logic                      SLEEP_REQUEST,
	input  wire logic                      FLOWTHRU_SELECT_N,
	input  wire logic                      LINEAR_ORDER_N,
	input  wire logic                      PARITY_SENSE_SELECT,
	input  wire logic [LANES*LANE_W-1:0]   DQ_IN,
	output logic      [LANES*LANE_W-1:0]   DQ_OUT,
	output logic                           DQ_OE,
	output logic                           PARITY_FAULT_OD_OUT,
	output logic                           PARITY_FAULT_OD_OE,
	output logic                           STANDBY
);

	localparam int DW      = LANES * LANE_W;
	localparam int DEPTH   = 1 << ADDR_W;
	localparam int BURST_W = `SBSC_BURST_W;

	// ----------------------------------------
	// Parity check of one lane
	// ----------------------------------------
	// Even sense wants a zero xor, odd sense a one
	function automatic logic lane_bad(input logic [LANE_W-1:0] lane, input logic even);
		return (^lane) == even;
	endfunction

	// ----------------------------------------
	// Write decode helpers
	// ----------------------------------------
	// Any write asked for, global or by lane
	function automatic logic write_decode(input logic all_n, input logic byte_n,
			input logic [LANES-1:0] lane_n);
		return ~all_n | (~byte_n & ~(&lane_n));
	endfunction

	// Lanes that a write cycle stores
	function automatic logic [LANES-1:0] lane_mask(input logic all_n, input logic byte_n,
			input logic [LANES-1:0] lane_n);
		logic [LANES-1:0] mask;
		mask = '0;
		if (!all_n) begin
			mask = '1;
		end else if (!byte_n) begin
			mask = ~lane_n;
		end
		return mask;
	endfunction

	// ----------------------------------------
	// Mode and sleep synchronisers
	// ----------------------------------------
	logic [`SBSC_MODE_W-1:0] mode_s1_q;
	logic [`SBSC_MODE_W-1:0] mode_s2_q;
	logic [`SBSC_MODE_W-1:0] mode_raw;

	assign mode_raw = {PARITY_SENSE_SELECT, LINEAR_ORDER_N, FLOWTHRU_SELECT_N, SLEEP_REQUEST};

	// Reset values match the defaults of floating mode pins
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			mode_s1_q <= `SBSC_MODE_RST;
			mode_s2_q <= `SBSC_MODE_RST;
		end else begin
			mode_s1_q <= mode_raw;
			mode_s2_q <= mode_s1_q;
		end
	end

	// ----------------------------------------
	// Decoded modes
	// ----------------------------------------
	// All active high after the synchroniser
	logic sleep_on;
	logic flow_mode;
	logic linear_mode;
	logic even_mode;

	assign sleep_on    = mode_s2_q[`SBSC_MODE_SLEEP];
	assign flow_mode   = ~mode_s2_q[`SBSC_MODE_FLOW];
	assign linear_mode = ~mode_s2_q[`SBSC_MODE_ORDER];
	assign even_mode   = mode_s2_q[`SBSC_MODE_PAR];

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// One array per lane so each lane has its own writer
	logic [LANE_W-1:0] mem_q [LANES][DEPTH];
	logic [DW-1:0]     rd_now;

	// ----------------------------------------
	// Cycle decode and burst address
	// ----------------------------------------
	logic [ADDR_W-1:0]     base_q;
	logic [ADDR_W-1:0]     base_d;
	logic [BURST_W-1:0]    cnt_q;
	logic [BURST_W-1:0]    cnt_d;
	logic                  wr_dec;
	logic [LANES-1:0]      lane_we;
	logic [BURST_W-1:0]    low_bits;
	logic [ADDR_W-1:0]     acc_addr;
	sbsc_pkg::sbsc_kind_t  kind;
	logic                  is_read;
	logic                  is_write;

	// ----------------------------------------
	// Write controls
	// ----------------------------------------
	// Same decode for start and continue cycles
	always_comb begin
		wr_dec  = write_decode(ALL_BYTES_WRITE_N, BYTE_WRITE_EN_N, BYTE_LANE_EN_N);
		lane_we = lane_mask(ALL_BYTES_WRITE_N, BYTE_WRITE_EN_N, BYTE_LANE_EN_N);
	end

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	// Sleep turns every command into a deselect
	always_comb begin
		kind   = sbsc_pkg::SBSC_DESEL;
		base_d = base_q;
		cnt_d  = cnt_q;
		if (sleep_on) begin
			kind = sbsc_pkg::SBSC_DESEL;
		end else if (CHIP_SELECT_N && !CTRL_ADDR_STROBE_N) begin
			kind = sbsc_pkg::SBSC_DESEL;
		end else if (!CHIP_SELECT_N && !PROC_ADDR_STROBE_N) begin
			// Processor strobe always reads
			kind   = sbsc_pkg::SBSC_READ;
			base_d = ADDR;
			cnt_d  = `SBSC_CNT_ZERO;
		end else if (!CHIP_SELECT_N && !CTRL_ADDR_STROBE_N) begin
			// Controller strobe reads or writes
			kind   = wr_dec ? sbsc_pkg::SBSC_WRITE : sbsc_pkg::SBSC_READ;
			base_d = ADDR;
			cnt_d  = `SBSC_CNT_ZERO;
		end else begin
			// No strobe taken, chip select at either level: continue the burst
			kind = wr_dec ? sbsc_pkg::SBSC_WRITE : sbsc_pkg::SBSC_READ;
			if (!BURST_ADVANCE_N) begin
				cnt_d = BURST_W'(cnt_q + `SBSC_CNT_STEP);
			end else begin
				cnt_d = cnt_q;
			end
		end
		// Low address bits follow the burst order
		if (linear_mode) begin
			low_bits = BURST_W'(base_d[BURST_W-1:0] + cnt_d);
		end else begin
			low_bits = base_d[BURST_W-1:0] ^ cnt_d;
		end
		acc_addr = {base_d[ADDR_W-1:BURST_W], low_bits};
	end

	assign is_read  = (kind == sbsc_pkg::SBSC_READ);
	assign is_write = (kind == sbsc_pkg::SBSC_WRITE);

	// ----------------------------------------
	// Burst address registers
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			base_q <= '0;
			cnt_q  <= `SBSC_CNT_ZERO;
		end else begin
			base_q <= base_d;
			cnt_q  <= cnt_d;
		end
	end

	// ----------------------------------------
	// Lane storage
	// ----------------------------------------
	// Write takes data and lane enables on the command edge
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		always_ff @(posedge CLK) begin
			if (is_write && lane_we[g]) begin
				mem_q[g][acc_addr] <= DQ_IN[g*LANE_W +: LANE_W];
			end
		end
		// Combinational read; flow mode needs it this cycle
		assign rd_now[g*LANE_W +: LANE_W] = mem_q[g][acc_addr];
	end

	// ----------------------------------------
	// Read path, drivers and parity
	// ----------------------------------------
	logic [DW-1:0] rd_q;
	logic [DW-1:0] rd_d;
	logic          pipe_en_q;
	logic          pipe_en_d;
	logic [DW-1:0] dq_out_q;
	logic [DW-1:0] dq_out_d;
	logic          dq_oe_q;
	logic          dq_oe_d;
	logic          pf_q;
	logic          pf_d;
	logic          pf_out_q;
	logic          standby_q;
	logic [LANES-1:0] bad_now;
	logic [LANES-1:0] bad_piped;

	// ----------------------------------------
	// Per-lane parity flags
	// ----------------------------------------
	for (genvar p = 0; p < LANES; p++) begin : g_par
		assign bad_now[p]   = lane_bad(rd_now[p*LANE_W +: LANE_W], even_mode);
		assign bad_piped[p] = lane_bad(rd_q[p*LANE_W +: LANE_W], even_mode);
	end

	// Pipelined outputs lag the command by one more edge
	always_comb begin
		rd_d      = rd_now;
		pipe_en_d = is_read;
		if (flow_mode) begin
			dq_out_d = rd_now;
			dq_oe_d  = is_read;
			pf_d     = is_read && (|bad_now);
		end else begin
			dq_out_d = rd_q;
			dq_oe_d  = pipe_en_q;
			pf_d     = pipe_en_q && (|bad_piped);
		end
	end

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rd_q      <= '0;
			pipe_en_q <= 1'b0;
			dq_out_q  <= '0;
			dq_oe_q   <= 1'b0;
			pf_q      <= 1'b0;
			pf_out_q  <= 1'b0;
			standby_q <= 1'b0;
		end else begin
			rd_q      <= rd_d;
			pipe_en_q <= pipe_en_d;
			dq_out_q  <= dq_out_d;
			dq_oe_q   <= dq_oe_d;
			pf_q      <= pf_d;
			pf_out_q  <= 1'b0;
			standby_q <= sleep_on;
		end
	end

	// ----------------------------------------
	// Ports
	// ----------------------------------------
	// Fault pin level is held low; its enable carries the fault
	assign DQ_OUT              = dq_out_q;
	assign DQ_OE               = dq_oe_q & ~OUTPUT_ENABLE_N;
	assign PARITY_FAULT_OD_OUT = pf_out_q;
	assign PARITY_FAULT_OD_OE  = pf_q;
	assign STANDBY             = standby_q;

endmodule

// ---- verif/sbsc_host_model.sv ----
// ----------------------------------------
// Bus side controller model
// ----------------------------------------
module sbsc_host_model (
	input  wire logic        clk,
	input  wire logic        drv,
	input  wire logic [35:0] wdat,
	input  wire logic [35:0] q,
	input  wire logic        q_oe,
	output logic      [35:0] dq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [35:0] last_q;
	always_ff @(posedge clk) last_q <= dq;
	// Released bus shows inverse of last level
	assign dq = drv ? wdat : q_oe ? q : ~last_q;
endmodule

// ---- verif/sbsc_tb.sv ----
// ----------------------------------------
// Reference model and stimulus
// ----------------------------------------
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rstn, cs_n, ps_n, cc_n, av_n, bwe_n, all_n, oe_n, slp, flow_n, lb_n, psel;
	logic        drv, q_oe, f_oe, f_od, stby, sb;
	logic [3:0]  ln_n;
	logic [5:0]  a, base;
	logic [1:0]  cnt;
	logic [35:0] wd, dq, q, dq_s;
	logic [35:0] mem [64];
	logic [37:0] en, ep, ex;
	int          err_total, n_compared;
	sbsc_top #(.ADDR_W(6)) dut (.CLK(clk), .RSTN(rstn), .ADDR(a), .CHIP_SELECT_N(cs_n),
		.PROC_ADDR_STROBE_N(ps_n), .CTRL_ADDR_STROBE_N(cc_n), .BURST_ADVANCE_N(av_n),
		.BYTE_WRITE_EN_N(bwe_n), .ALL_BYTES_WRITE_N(all_n), .BYTE_LANE_EN_N(ln_n),
		.OUTPUT_ENABLE_N(oe_n), .SLEEP_REQUEST(slp), .FLOWTHRU_SELECT_N(flow_n),
		.LINEAR_ORDER_N(lb_n), .PARITY_SENSE_SELECT(psel), .DQ_IN(dq), .DQ_OUT(q), .DQ_OE(q_oe),
		.PARITY_FAULT_OD_OUT(f_od), .PARITY_FAULT_OD_OE(f_oe), .STANDBY(stby));
	sbsc_host_model host (.clk(clk), .drv(drv), .wdat(wd), .q(q), .q_oe(q_oe), .dq(dq));
	function automatic logic par(logic [35:0] d);
		par = 1'b0;
		for (int i = 0; i < 4; i++) if (^d[9*i+:9] != !psel) par = 1'b1;
	endfunction
	task automatic chk(logic [35:0] s, logic [35:0] e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic model();
		logic [1:0] lo;
		logic       w;
		ep = en;
		en = '0;
		if (slp || cs_n && !cc_n) return;
		if (!cs_n && !(ps_n && cc_n)) begin
			base = a;
			cnt = 2'h0;
		end else if (!av_n) cnt = cnt + 2'h1;
		lo = lb_n ? base[1:0] ^ cnt : base[1:0] + cnt;
		w = (!all_n || !bwe_n && !(&ln_n)) && !(!cs_n && !ps_n);
		for (int i = 0; i < 4; i++)
			if (w && (!all_n || !ln_n[i])) mem[{base[5:2], lo}][9*i+:9] = dq_s[9*i+:9];
		en = {!w, par(mem[{base[5:2], lo}]), mem[{base[5:2], lo}]};
	endtask
	task automatic tick();
		@(negedge clk);
		ex = flow_n ? ep : en;
		sb = stby;
		chk(36'(q_oe), 36'(ex[37] && !oe_n));
		if (ex[37] && !oe_n) chk(q, ex[35:0]);
		if (ex[37]) chk(36'(f_oe), 36'(ex[36]));
		dq_s = dq;
		@(posedge clk);
		model();
	endtask
	task automatic go(logic [9:0] c, logic [5:0] ad);
		{cs_n, ps_n, cc_n, av_n, bwe_n, all_n, ln_n} <= c;
		a <= ad;
		wd <= 36'({$urandom, $urandom});
		drv <= !c[4] || !c[5] && !(&c[3:0]);
		tick();
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rstn, oe_n, slp, flow_n, lb_n, psel, drv} = 7'h0f;
		{cs_n, ps_n, cc_n, av_n, bwe_n, all_n, ln_n} = 10'h37f;
		{a, wd, base, cnt, en, ep} = '0;
		void'($urandom(32'h453a7517));
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 64; i++) go(10'h16f, 6'(i));
		for (int m = 0; m < 8; m++) begin
			// Modes change only between idle spells; the design sees them two edges late
			repeat (4) go(10'h37f, 6'h0);
			{flow_n, lb_n, psel} <= 3'(m);
			repeat (4) go(10'h37f, 6'h0);
			go(10'h17f, 6'(m * 9 + 1));
			oe_n <= 1'b1;
			go(10'h3bf, 6'h0);
			oe_n <= 1'b0;
			go(10'h3ff, 6'h0);
			repeat (3) go(10'h3bf, 6'h0);
			go(10'h395, 6'h0);
			repeat (2) go(10'h3ff, 6'h0);
			repeat (150) begin
				oe_n <= ($urandom % 5) == 0;
				go(10'($urandom), 6'($urandom));
			end
		end
		slp <= 1'b1;
		repeat (5) go(10'h37f, 6'h0);
		chk(36'(sb), 36'h1);
		go(10'h16f, 6'h5);
		repeat (3) go(10'h37f, 6'h0);
		slp <= 1'b0;
		repeat (5) go(10'h37f, 6'h0);
		chk(36'(sb), 36'h0);
		go(10'h0ff, 6'h5);
		repeat (2) go(10'h37f, 6'h0);
		results();
	end
endmodule

// ---- verif/sbsc_top_asserts.sv ----
// ----------------------------------------
// Port checks
// ----------------------------------------
module sbsc_top_asserts #(
	parameter int LANES = 4
) (
	input wire logic             CLK,
	input wire logic             RSTN,
	input wire logic             CHIP_SELECT_N,
	input wire logic             PROC_ADDR_STROBE_N,
	input wire logic             CTRL_ADDR_STROBE_N,
	input wire logic             BYTE_WRITE_EN_N,
	input wire logic             ALL_BYTES_WRITE_N,
	input wire logic [LANES-1:0] BYTE_LANE_EN_N,
	input wire logic             OUTPUT_ENABLE_N,
	input wire logic             SLEEP_REQUEST,
	input wire logic             FLOWTHRU_SELECT_N,
	input wire logic             DQ_OE,
	input wire logic             PARITY_FAULT_OD_OUT,
	input wire logic             STANDBY
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wr, rd, ds;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	assign wr = (!ALL_BYTES_WRITE_N || !BYTE_WRITE_EN_N && !(&BYTE_LANE_EN_N)) && !SLEEP_REQUEST
		&& (CTRL_ADDR_STROBE_N ? PROC_ADDR_STROBE_N || CHIP_SELECT_N
		: !CHIP_SELECT_N && PROC_ADDR_STROBE_N);
	assign rd = !CHIP_SELECT_N && !PROC_ADDR_STROBE_N && !SLEEP_REQUEST && !STANDBY;
	assign ds = CHIP_SELECT_N && !CTRL_ADDR_STROBE_N;
	chk_fault_level_low: assert property (!PARITY_FAULT_OD_OUT)
		else $error("fault level not low");
	chk_oe_gate_off: assert property (OUTPUT_ENABLE_N |-> !DQ_OE)
		else $error("driver on with enable high");
	chk_write_pipe_off: assert property (wr && FLOWTHRU_SELECT_N |-> ##2 !DQ_OE)
		else $error("driver on for pipelined write");
	chk_write_flow_off: assert property (wr && !FLOWTHRU_SELECT_N |=> !DQ_OE)
		else $error("driver on for flow write");
	chk_desel_pipe_off: assert property (ds && FLOWTHRU_SELECT_N |-> ##2 !DQ_OE)
		else $error("pipelined deselect not off");
	chk_desel_flow_off: assert property (ds && !FLOWTHRU_SELECT_N |=> !DQ_OE)
		else $error("flow deselect not off");
	chk_read_pipe_on: assert property (rd && FLOWTHRU_SELECT_N ##2 !OUTPUT_ENABLE_N |-> DQ_OE)
		else $error("pipelined read not driven");
	chk_read_flow_on: assert property (rd && !FLOWTHRU_SELECT_N ##1 !OUTPUT_ENABLE_N |-> DQ_OE)
		else $error("flow read not driven");
	chk_sleep_enter: assert property ($rose(SLEEP_REQUEST) |=> !STANDBY ##[0:3] STANDBY)
		else $error("standby not entered");
	chk_sleep_leave: assert property ($fell(SLEEP_REQUEST) |-> ##[1:4] !STANDBY)
		else $error("standby not left");
endmodule

bind sbsc_top sbsc_top_asserts #(.LANES(LANES)) u_chk (.*);
